// ---- hw/bsp_regs.svh ----
// constants of the background serial port sequencer
`ifndef BSP_REGS_SVH
`define BSP_REGS_SVH

// ****************************************
// clock and timing
// ****************************************
`define BSP_CLK_NS 10
`define BSP_CS_PULSE_NS 1000
`define BSP_CS_PULSE_CYC ((`BSP_CS_PULSE_NS + `BSP_CLK_NS - 1) / `BSP_CLK_NS)

// ****************************************
// serial mode values and half periods
// ****************************************
`define BSP_MODE_A 8'h14
`define BSP_MODE_B 8'h15
`define BSP_MODE_C 8'h16
`define BSP_HALF_A 8'h02
`define BSP_HALF_B 8'h04
`define BSP_HALF_C 8'h08

// ****************************************
// command field values
// ****************************************
`define BSP_SEL_ZERO 16'h0000
`define BSP_SEL_ONES 16'hFFFF
`define BSP_CS_NONE 2'h0
`define BSP_CS_FALL 2'h1
`define BSP_CS_RISE 2'h2
`define BSP_CS_RESET 1'b1

`endif

// ---- hw/bsp_pkg.sv ----
// types of the background serial port sequencer
package bsp_pkg;

  typedef struct packed {
    logic signed [15:0] ops;
    logic signed [15:0] src;
    logic signed [15:0] dst;
    logic [2:0] nbytes;
    logic [1:0] cs_mode;
    logic handshake;
  } bsp_cmd_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_CSP  = 4'b0010,
    S_WAIT = 4'b0100,
    S_RUN  = 4'b1000
  } bsp_state_t;

endpackage : bsp_pkg

// ---- hw/bsp_shifter.sv ----
// full-duplex byte shifter driving the serial clock
`timescale 1ns/1ps
module bsp_shifter
  import bsp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic start_i,
  input wire logic [31:0] tx_i,
  input wire logic [5:0] nbits_i,
  input wire logic [7:0] half_i,
  input wire logic miso_i,
  output logic done_o,
  output logic [31:0] rx_o,
  // pins
  output logic sclk_o,
  output logic mosi_o
);

  logic busy_r, busy_nxt, done_r, done_nxt, sclk_r, sclk_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [5:0] bits_r, bits_nxt;
  logic [31:0] sh_r, sh_nxt, rx_r, rx_nxt;

  // ****************************************
  // shift engine
  // ****************************************
  always_comb begin
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    sclk_nxt = sclk_r;
    cnt_nxt = cnt_r;
    bits_nxt = bits_r;
    sh_nxt = sh_r;
    rx_nxt = rx_r;
    if (start_i && !busy_r) begin
      busy_nxt = 1'b1;
      sclk_nxt = 1'b0;
      cnt_nxt = half_i - 8'h01;
      bits_nxt = nbits_i;
      sh_nxt = tx_i;
      rx_nxt = 32'h0000_0000;
    end else if (busy_r) begin
      if (cnt_r == 8'h00) begin
        cnt_nxt = half_i - 8'h01;
        if (!sclk_r) begin
          sclk_nxt = 1'b1;
        end else begin
          // sample at the end of the high half: the two-flop miso delay
          // would hand over the previous bit at a two-clock half period
          sclk_nxt = 1'b0;
          rx_nxt = {rx_r[30:0], miso_i};
          sh_nxt = {sh_r[30:0], 1'b0};
          bits_nxt = bits_r - 6'h01;
          if (bits_r == 6'h01) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
          end
        end
      end else begin
        cnt_nxt = cnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      sclk_r <= 1'b0;
      cnt_r <= 8'h00;
      bits_r <= 6'h00;
      sh_r <= 32'h0000_0000;
      rx_r <= 32'h0000_0000;
    end else begin
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      sclk_r <= sclk_nxt;
      cnt_r <= cnt_nxt;
      bits_r <= bits_nxt;
      sh_r <= sh_nxt;
      rx_r <= rx_nxt;
    end
  end

  assign done_o = done_r;
  assign rx_o = rx_r;
  assign sclk_o = sclk_r;
  assign mosi_o = sh_r[31];

endmodule : bsp_shifter

// ---- hw/bsp_seq.sv ----
// background serial port sequencer: command, chip select, handshake, registers
// Function
// - shift out and capture every transfer
// - operation count sets repeated cycles
// - negative count advances an index each cycle
// - advance source, else destination when special
// - source zero sends zeros, minus one ones
// - destination zero discards received data
// - one to four low-order bytes per cycle
// - most significant selected byte goes first
// - select mode zero leaves select untouched
// - mode one pulses high then low
// - mode two pulses low then high
// - handshake waits for peripheral output low
// - timing comes from serial mode value
// - select pulsing repeats across commands
`include "bsp_regs.svh"
`timescale 1ns/1ps
module bsp_seq
  import bsp_pkg::*;
#(
  parameter int CS_PULSE = `BSP_CS_PULSE_CYC
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // command port
  input wire logic cmd_valid_i,
  input wire bsp_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic busy_o,
  // serial mode setting
  input wire logic [7:0] serial_mode_select_command_i,
  // data register access
  output logic [15:0] rd_idx_o,
  input wire logic [31:0] rd_data_i,
  output logic wr_en_o,
  output logic [15:0] wr_idx_o,
  output logic [31:0] wr_data_o,
  // link pins
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_i,
  output logic cs_o
);

  bsp_state_t state_r, state_nxt;
  bsp_cmd_t cmd_r, cmd_nxt;
  logic [15:0] left_r, left_nxt;
  logic [15:0] pulse_r, pulse_nxt;
  logic cs_r, cs_nxt;
  logic wr_en_r, wr_en_nxt;
  logic [15:0] wr_idx_r, wr_idx_nxt;
  logic [31:0] wr_data_r, wr_data_nxt;
  logic miso_m_r, miso_s_r;
  logic accept, start, done;
  logic [31:0] tx_w, rx_w;
  logic [7:0] half_w;

  // ****************************************
  // helpers
  // ****************************************
  // unknown mode values fall back to the fastest, first mode
  function automatic logic [7:0] half_of(input logic [7:0] m);
    unique case (m)
      `BSP_MODE_B: half_of = `BSP_HALF_B;
      `BSP_MODE_C: half_of = `BSP_HALF_C;
      default: half_of = `BSP_HALF_A;
    endcase
  endfunction : half_of

  function automatic logic special(input logic [15:0] s);
    special = (s == `BSP_SEL_ZERO) || (s == `BSP_SEL_ONES);
  endfunction : special

  assign half_w = half_of(serial_mode_select_command_i);

  // ****************************************
  // miso synchroniser
  // ****************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      miso_m_r <= 1'b1;
      miso_s_r <= 1'b1;
    end else begin
      miso_m_r <= miso_i;
      miso_s_r <= miso_m_r;
    end
  end

  // ****************************************
  // transmit word
  // ****************************************
  always_comb begin
    if (cmd_r.src == `BSP_SEL_ZERO) begin
      tx_w = 32'h0000_0000;
    end else if (cmd_r.src == `BSP_SEL_ONES) begin
      tx_w = 32'hFFFF_FFFF;
    end else begin
      tx_w = rd_data_i << (6'(3'h4 - cmd_r.nbytes) * 6'h08);
    end
  end

  assign accept = cmd_valid_i && cmd_ready_o;
  assign start = (state_r == S_WAIT) && (!cmd_r.handshake || !miso_s_r);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    left_nxt = left_r;
    pulse_nxt = pulse_r;
    cs_nxt = cs_r;
    wr_en_nxt = 1'b0;
    wr_idx_nxt = wr_idx_r;
    wr_data_nxt = wr_data_r;
    unique case (state_r)
      S_IDLE: begin
        if (accept && cmd_i.ops != 16'sh0000) begin
          cmd_nxt = cmd_i;
          left_nxt = cmd_i.ops[15] ? 16'(-cmd_i.ops) : cmd_i.ops;
          pulse_nxt = 16'(CS_PULSE);
          if (cmd_i.cs_mode == `BSP_CS_FALL) begin
            cs_nxt = 1'b1;
            state_nxt = S_CSP;
          end else if (cmd_i.cs_mode == `BSP_CS_RISE) begin
            cs_nxt = 1'b0;
            state_nxt = S_CSP;
          end else begin
            state_nxt = S_WAIT;
          end
        end
      end
      S_CSP: begin
        pulse_nxt = pulse_r - 16'h0001;
        if (pulse_r == 16'h0001) begin
          cs_nxt = (cmd_r.cs_mode == `BSP_CS_RISE);
          state_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        if (start) begin
          state_nxt = S_RUN;
        end
      end
      S_RUN: begin
        if (done) begin
          wr_en_nxt = (cmd_r.dst != `BSP_SEL_ZERO);
          wr_idx_nxt = cmd_r.dst;
          wr_data_nxt = rx_w;
          if (cmd_r.ops[15]) begin
            if (special(cmd_r.src)) begin
              cmd_nxt.dst = cmd_r.dst + 16'sh0001;
            end else begin
              cmd_nxt.src = cmd_r.src + 16'sh0001;
            end
          end
          left_nxt = left_r - 16'h0001;
          state_nxt = (left_r == 16'h0001) ? S_IDLE : S_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= S_IDLE;
      cmd_r <= '0;
      left_r <= 16'h0000;
      pulse_r <= 16'h0000;
      cs_r <= `BSP_CS_RESET;
      wr_en_r <= 1'b0;
      wr_idx_r <= 16'h0000;
      wr_data_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      left_r <= left_nxt;
      pulse_r <= pulse_nxt;
      cs_r <= cs_nxt;
      wr_en_r <= wr_en_nxt;
      wr_idx_r <= wr_idx_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  // ****************************************
  // shifter and outputs
  // ****************************************
  bsp_shifter u_shift (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(start),
    .tx_i(tx_w),
    .nbits_i({cmd_r.nbytes, 3'h0}),
    .half_i(half_w),
    .miso_i(miso_s_r),
    .done_o(done),
    .rx_o(rx_w),
    .sclk_o(sclk_o),
    .mosi_o(mosi_o)
  );

  assign cmd_ready_o = (state_r == S_IDLE);
  assign busy_o = (state_r != S_IDLE);
  assign rd_idx_o = cmd_r.src;
  assign wr_en_o = wr_en_r;
  assign wr_idx_o = wr_idx_r;
  assign wr_data_o = wr_data_r;
  assign cs_o = cs_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_busy_holds_cmd: assert property (busy_o && cmd_valid_i |=> $stable(cmd_r.nbytes))
    else $error("command changed while busy");
  a_zero_fill: assert property (start && cmd_r.src == `BSP_SEL_ZERO |=> !mosi_o)
    else $error("zero fill sent a one");
  a_ones_fill: assert property (start && cmd_r.src == `BSP_SEL_ONES |=> mosi_o)
    else $error("ones fill sent a zero");
  a_no_discard_write: assert property (wr_en_o |-> wr_idx_o != 16'h0000)
    else $error("write to discard index");
  a_cs_fall_edge: assert property (accept && cmd_i.ops != 16'sh0000 && cmd_i.cs_mode == `BSP_CS_FALL
    |=> cs_o && state_r == S_CSP)
    else $error("select did not pulse high");
  a_cs_rise_edge: assert property ($fell(state_r == S_CSP) && cmd_r.cs_mode == `BSP_CS_RISE |-> cs_o)
    else $error("select not left high");
  a_cs_untouched: assert property (state_r == S_IDLE ##1 state_r == S_WAIT |-> $stable(cs_o))
    else $error("select moved in mode zero");
  a_hs_wait: assert property (state_r == S_WAIT && cmd_r.handshake && miso_s_r |=> state_r == S_WAIT)
    else $error("cycle started before handshake");
  a_src_advance: assert property (done && state_r == S_RUN && cmd_r.ops[15] && !special(cmd_r.src)
    |=> cmd_r.src == $past(cmd_r.src) + 16'sh0001)
    else $error("source index not advanced");
  a_dst_advance: assert property (done && state_r == S_RUN && cmd_r.ops[15] && special(cmd_r.src)
    |=> cmd_r.dst == $past(cmd_r.dst) + 16'sh0001)
    else $error("destination index not advanced");
  a_last_cycle: assert property (done && state_r == S_RUN && left_r == 16'h0001 |=> state_r == S_IDLE)
    else $error("sequence ran past its count");
  a_rx_aligned: assert property (wr_en_o && cmd_r.nbytes == 3'h1 |-> wr_data_o[31:8] == 24'h000000)
    else $error("upper bytes not cleared");

  c_fall_mode: cover property (accept && cmd_i.cs_mode == `BSP_CS_FALL);
  c_rise_mode: cover property (accept && cmd_i.cs_mode == `BSP_CS_RISE);
  c_hs_stall: cover property (state_r == S_WAIT && cmd_r.handshake && miso_s_r);
  c_neg_run: cover property (wr_en_o && cmd_r.ops[15]);

endmodule : bsp_seq

// ---- tb/bsp_spi_model.sv ----
// behavioural peripheral on the far side of the serial link
`timescale 1ns/1ps
module bsp_spi_model #(
  parameter logic [31:0] PAT = 32'h1E2D3C4B
)(
  // link pins
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  // control
  input wire logic hold_i,
  output logic [31:0] got_o
);
  // *****
  // shift both ways
  // *****
  logic [31:0] pat_r = PAT;
  initial got_o = 32'h0;
  always @(posedge sclk_i) got_o <= {got_o[30:0], mosi_i};
  // every byte of the pattern starts low, so a ready peripheral shows low
  always @(negedge sclk_i) pat_r <= {pat_r[30:0], pat_r[31]};
  assign miso_o = hold_i ? 1'b1 : pat_r[31];
endmodule : bsp_spi_model

// ---- tb/bsp_seq_tb.sv ----
// self-checking bench of the background serial port sequencer
`timescale 1ns/1ps
module bsp_seq_tb;
  import bsp_pkg::*;
  // *****
  // signals
  // *****
  localparam logic [31:0] PAT = 32'h1E2D3C4B;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  bsp_cmd_t cmd_i = '0;
  logic [7:0] mode = 8'h14;
  logic hold = 1'b0;
  logic cmd_ready_o, busy_o, wr_en_o, sclk_o, mosi_o, miso, cs_o, cs_prev;
  logic [15:0] rd_idx_o, wr_idx_o;
  logic [31:0] wr_data_o, got;
  bsp_cmd_t cur, rows [6];
  logic [7:0] mds [6], hlf [6];
  int fails = 0;
  int n_tests = 0;
  int wrs = 0, rot = 0, edges = 0, hrun = 0, lastrun = 0;
  function automatic logic [31:0] regv(input logic [15:0] i);
    return {8'h81, i[7:0], 8'h7E, ~i[7:0]};
  endfunction : regv
  function automatic logic [31:0] msk(input logic [2:0] n);
    return (n == 3'h4) ? 32'hFFFFFFFF : ((32'h1 << (8 * n)) - 32'h1);
  endfunction : msk
  function automatic logic spec();
    return cur.src == 16'sh0000 || cur.src == 16'shFFFF;
  endfunction : spec
  function automatic logic [15:0] didx(input int j);
    return (cur.ops < 0 && spec()) ? 16'(cur.dst + j) : cur.dst;
  endfunction : didx
  function automatic logic [31:0] txv(input int j);
    logic [31:0] v;
    v = spec() ? {32{cur.src[0]}} : regv((cur.ops < 0) ? 16'(cur.src + j) : cur.src);
    return v & msk(cur.nbytes);
  endfunction : txv
  function automatic logic [31:0] rxv(input int r);
    logic [63:0] p;
    p = {PAT, PAT} << (r % 32);
    return p[63:32] >> (32 - 8 * cur.nbytes);
  endfunction : rxv
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // *****
  // design and peripheral
  // *****
  bsp_seq #(.CS_PULSE(2)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o), .busy_o(busy_o), .serial_mode_select_command_i(mode),
    .rd_idx_o(rd_idx_o), .rd_data_i(regv(rd_idx_o)), .wr_en_o(wr_en_o), .wr_idx_o(wr_idx_o),
    .wr_data_o(wr_data_o), .sclk_o(sclk_o), .mosi_o(mosi_o), .miso_i(miso), .cs_o(cs_o)
  );
  bsp_spi_model #(.PAT(PAT)) peer (
    .sclk_i(sclk_o), .mosi_i(mosi_o), .miso_o(miso), .hold_i(hold), .got_o(got)
  );
  initial forever #5 clk_i = ~clk_i;
  // settled values are looked at on the falling edge
  always @(negedge clk_i) begin
    if (cs_o !== cs_prev) edges++;
    cs_prev = cs_o;
    if (sclk_o === 1'b1) hrun++;
    else if (hrun != 0) begin
      lastrun = hrun;
      hrun = 0;
    end
    if (wr_en_o === 1'b1) begin
      chk("wr_idx", {16'h0, wr_idx_o}, {16'h0, didx(wrs)});
      chk("wr_data", wr_data_o, rxv(rot + 8 * wrs * cur.nbytes));
      chk("mosi", got & msk(cur.nbytes), txv(wrs));
      wrs++;
    end
  end
  task automatic run(input bsp_cmd_t c, input logic [7:0] m, input logic [7:0] h);
    int t, n, ce;
    logic cs0;
    cur = c;
    wrs = 0;
    edges = 0;
    cs0 = cs_o;
    n = (c.ops < 0) ? -int'(c.ops) : int'(c.ops);
    ce = (c.cs_mode == 2'h0 || n == 0) ? 0 : ((cs0 == c.cs_mode[1]) ? 2 : 1);
    @(posedge clk_i);
    cmd_i <= c;
    mode <= m;
    cmd_valid_i <= 1'b1;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    t = 0;
    @(negedge clk_i);
    while (busy_o !== 1'b0 && t < 9000) begin
      @(negedge clk_i);
      t++;
    end
    // last write pulse shares its cycle with busy falling
    @(negedge clk_i);
    chk("busy", {31'h0, busy_o}, 32'h0);
    chk("writes", wrs, (c.dst == 16'sh0000) ? 0 : n);
    chk("cs_edges", edges, ce);
    chk("cs_level", {31'h0, cs_o}, {31'h0, (ce == 0) ? cs0 : c.cs_mode[1]});
    if (n > 0) begin
      chk("half", lastrun, {24'h0, h});
      chk("mosi_last", got & msk(c.nbytes), txv(n - 1));
    end
    rot += 8 * n * c.nbytes;
  endtask : run
  task automatic chk_rst();
    chk("reset_out", {26'h0, cmd_ready_o, busy_o, cs_o, sclk_o, wr_en_o, mosi_o}, 32'h28);
  endtask : chk_rst
  // *****
  // sequence
  // *****
  initial begin
    rows = '{'{16'sh0001, 16'sh001E, 16'sh0028, 3'h4, 2'h1, 1'b0}, '{16'shFFFD, 16'sh0014, 16'sh0032, 3'h2, 2'h1, 1'b0},
      '{16'shFFFE, 16'sh0000, 16'sh003C, 3'h1, 2'h0, 1'b0}, '{16'shFFFE, 16'shFFFF, 16'sh0046, 3'h3, 2'h2, 1'b0},
      '{16'sh0002, 16'sh0023, 16'sh0000, 3'h4, 2'h2, 1'b1}, '{16'sh0001, 16'sh000C, 16'sh000D, 3'h1, 2'h0, 1'b0}};
    mds = '{8'h14, 8'h15, 8'h16, 8'h14, 8'h15, 8'h4D};
    hlf = '{8'h02, 8'h04, 8'h08, 8'h02, 8'h04, 8'h02};
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk_rst();
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (rows[i]) run(rows[i], mds[i], hlf[i]);
    @(posedge clk_i);
    hold <= 1'b1;
    fork
      run('{16'sh0001, 16'sh000B, 16'sh000C, 3'h1, 2'h0, 1'b1}, 8'h14, 8'h02);
      begin
        repeat (40) @(posedge clk_i);
        chk("stall", {30'h0, busy_o, hrun != 0}, 32'h2);
        chk("stall_wr", wrs, 0);
        hold <= 1'b0;
      end
    join
    fork
      run('{16'sh0003, 16'sh000B, 16'sh000C, 3'h1, 2'h0, 1'b0}, 8'h14, 8'h02);
      begin
        repeat (8) @(posedge clk_i);
        cmd_i <= '{16'sh0001, 16'sh000D, 16'sh0063, 3'h2, 2'h1, 1'b0};
        cmd_valid_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        cmd_valid_i <= 1'b0;
      end
    join
    repeat (20) @(negedge clk_i);
    chk("refused", {31'h0, busy_o}, 32'h0);
    run('{16'sh0000, 16'sh000B, 16'sh000C, 3'h1, 2'h1, 1'b0}, 8'h14, 8'h02);
    // reset in mid-sequence must retire it at once
    @(posedge clk_i);
    cmd_i <= '{16'sh0002, 16'sh000B, 16'sh0000, 3'h4, 2'h1, 1'b0};
    cmd_valid_i <= 1'b1;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(negedge clk_i);
    chk_rst();
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    run('{16'shFFFF, 16'sh0000, 16'sh0000, 3'h2, 2'h2, 1'b0}, 8'h16, 8'h08);
    summarize();
  end
  initial begin
    #400000;
    fails++;
    summarize();
  end
endmodule : bsp_seq_tb
